// ---- design/prom_io_port_bus_slave.v ----
// program memory and two bidirectional ports on a multiplexed bus
`timescale 1ns/1ps
`default_nettype none
`include "prom_io_defines.vh"
module prom_io_port_bus_slave (
	input  wire        clk,
	input  wire        srst,
	input  wire        clk_en,
	input  wire        addr_latch_strobe,
	input  wire        io_mem_select,
	input  wire        read_strobe_n,
	input  wire        port_read_strobe_n,
	input  wire        port_write_strobe_n,
	input  wire        chip_enable_low,
	input  wire        chip_enable_high,
	input  wire [2:0]  upper_addr,
	input  wire [7:0]  shared_addr_data_bus_in,
	output reg  [7:0]  shared_addr_data_bus_out,
	output reg         shared_addr_data_bus_oe,
	input  wire [7:0]  port_a_pins_in,
	output reg  [7:0]  port_a_pins_out,
	output reg  [7:0]  port_a_pins_oe,
	input  wire [7:0]  port_b_pins_in,
	output reg  [7:0]  port_b_pins_out,
	output reg  [7:0]  port_b_pins_oe,
	output reg         wait_out,
	output reg         wait_oe
);
	// ----------------------------------------
	// synchronisers and strobe edge detection
	// ----------------------------------------
	reg [6:0]  ctl_s1_q;
	reg [6:0]  ctl_s2_q;
	reg [6:0]  ctl_s3_q;
	reg [6:0]  ctl_q;
	reg [7:0]  bus_s1_q;
	reg [7:0]  bus_s2_q;
	reg [7:0]  bus_s3_q;
	reg [2:0]  up_s1_q;
	reg [2:0]  up_s2_q;
	reg [2:0]  up_s3_q;
	reg [7:0]  pa_s1_q;
	reg [7:0]  pa_s2_q;
	reg [7:0]  pa_s3_q;
	reg [7:0]  pb_s1_q;
	reg [7:0]  pb_s2_q;
	reg [7:0]  pb_s3_q;
	reg [7:0]  pa_q;
	reg [7:0]  pb_q;
	wire [6:0] ctl_raw;
	assign ctl_raw = {chip_enable_high, chip_enable_low, port_write_strobe_n,
		port_read_strobe_n, read_strobe_n, io_mem_select, addr_latch_strobe};
	// a bit moves once stages two and three agree, else it holds
	function [7:0] settle;
		input [7:0] cur;
		input [7:0] mid;
		input [7:0] old;
		begin
			settle = (mid & old) | (cur & (mid | old));
		end
	endfunction
	wire [7:0] ctl_next;
	wire [7:0] pa_next;
	wire [7:0] pb_next;
	assign ctl_next = settle({1'b0, ctl_q}, {1'b0, ctl_s2_q}, {1'b0, ctl_s3_q});
	assign pa_next  = settle(pa_q, pa_s2_q, pa_s3_q);
	assign pb_next  = settle(pb_q, pb_s2_q, pb_s3_q);
	// control strobes: three stages, then the agreement filter
	always @(posedge clk) begin
		if (srst) begin
			ctl_s1_q <= `CTL_IDLE;
			ctl_s2_q <= `CTL_IDLE;
			ctl_s3_q <= `CTL_IDLE;
			ctl_q    <= `CTL_IDLE;
		end else if (clk_en) begin
			ctl_s1_q <= ctl_raw;
			ctl_s2_q <= ctl_s1_q;
			ctl_s3_q <= ctl_s2_q;
			ctl_q    <= ctl_next[6:0];
		end
	end
	// bus and upper address; stage three lines up with the strobes
	always @(posedge clk) begin
		if (srst) begin
			bus_s1_q <= 8'h00;
			bus_s2_q <= 8'h00;
			bus_s3_q <= 8'h00;
			up_s1_q  <= 3'h0;
			up_s2_q  <= 3'h0;
			up_s3_q  <= 3'h0;
		end else if (clk_en) begin
			bus_s1_q <= shared_addr_data_bus_in;
			bus_s2_q <= bus_s1_q;
			bus_s3_q <= bus_s2_q;
			up_s1_q  <= upper_addr;
			up_s2_q  <= up_s1_q;
			up_s3_q  <= up_s2_q;
		end
	end
	// port a pin levels
	always @(posedge clk) begin
		if (srst) begin
			pa_s1_q <= 8'h00;
			pa_s2_q <= 8'h00;
			pa_s3_q <= 8'h00;
			pa_q    <= 8'h00;
		end else if (clk_en) begin
			pa_s1_q <= port_a_pins_in;
			pa_s2_q <= pa_s1_q;
			pa_s3_q <= pa_s2_q;
			pa_q    <= pa_next;
		end
	end
	// port b pin levels
	always @(posedge clk) begin
		if (srst) begin
			pb_s1_q <= 8'h00;
			pb_s2_q <= 8'h00;
			pb_s3_q <= 8'h00;
			pb_q    <= 8'h00;
		end else if (clk_en) begin
			pb_s1_q <= port_b_pins_in;
			pb_s2_q <= pb_s1_q;
			pb_s3_q <= pb_s2_q;
			pb_q    <= pb_next;
		end
	end
	// filtered control levels
	wire ale;
	wire iom;
	wire rd_n;
	wire iord_n;
	wire iowr_n;
	wire ce_lo;
	wire ce_hi;
	wire ce_now;
	assign ale    = ctl_q[0];
	assign iom    = ctl_q[1];
	assign rd_n   = ctl_q[2];
	assign iord_n = ctl_q[3];
	assign iowr_n = ctl_q[4];
	assign ce_lo  = ctl_q[5];
	assign ce_hi  = ctl_q[6];
	assign ce_now = ~ce_lo & ce_hi;
	reg  ale_prev_q;
	reg  iowr_prev_q;
	wire ale_fall;
	wire iowr_rise;
	assign ale_fall  = ale_prev_q & ~ale;
	assign iowr_rise = ~iowr_prev_q & iowr_n;
	// ----------------------------------------
	// address latch and decode
	// ----------------------------------------
	reg [7:0]  addr_lo_q;
	reg        ce_q;
	reg        iom_q;
	reg [2:0]  addr_hi_q;
	// register select from the two low latched address bits
	function [3:0] sel_decode;
		input [1:0] a;
		begin
			sel_decode = 4'h1 << a;
		end
	endfunction
	wire [3:0] sel;
	assign sel = sel_decode(addr_lo_q[1:0]);
	// edge history of the filtered strobes, idle levels after reset
	always @(posedge clk) begin
		if (srst) begin
			ale_prev_q  <= 1'b0;
			iowr_prev_q <= 1'b1;
		end else if (clk_en) begin
			ale_prev_q  <= ale;
			iowr_prev_q <= iowr_n;
		end
	end
	// address phase capture on the filtered strobe fall
	always @(posedge clk) begin
		if (srst) begin
			addr_lo_q   <= 8'h00;
			ce_q        <= 1'b0;
			iom_q       <= 1'b0;
			addr_hi_q   <= 3'h0;
		end else if (clk_en) begin
			if (ale_fall) begin
				addr_lo_q <= bus_s3_q;
				ce_q      <= ce_now;
				iom_q     <= iom;
				addr_hi_q <= up_s3_q;
			end
		end
	end
	// ----------------------------------------
	// program memory
	// ----------------------------------------
	reg  [7:0] mem [0:`MEM_DEPTH-1];
	wire [`MEM_ADDR_W-1:0] mem_addr;
	assign mem_addr = {addr_hi_q, addr_lo_q};
	integer i;
	// contents fixed at build time; erased cells read as all ones
	initial begin
		for (i = 0; i < `MEM_DEPTH; i = i + 1) begin
			mem[i] = 8'hff;
		end
	end
	wire [7:0] mem_byte;
	assign mem_byte = mem[mem_addr];
	// ----------------------------------------
	// port, direction and pin registers
	// ----------------------------------------
	reg [7:0] pa_lat_q;
	reg [7:0] pb_lat_q;
	reg [7:0] dir_a_q;
	reg [7:0] dir_b_q;
	reg       wr_pend_q;
	wire      wr_go;
	// write qualifier: enables latched and port write strobe low
	assign wr_go = ce_q && !iowr_n;
	// output latches load while the strobe is low, whatever the direction
	always @(posedge clk) begin
		if (srst) begin
			pa_lat_q <= `PORT_RESET;
			pb_lat_q <= `PORT_RESET;
		end else if (clk_en) begin
			if (wr_go && sel[0]) begin
				pa_lat_q <= bus_s3_q;
			end
			if (wr_go && sel[1]) begin
				pb_lat_q <= bus_s3_q;
			end
		end
	end
	// direction registers; reset puts every pin in input mode
	always @(posedge clk) begin
		if (srst) begin
			dir_a_q <= `DIR_RESET;
			dir_b_q <= `DIR_RESET;
		end else if (clk_en) begin
			if (wr_go && sel[2]) begin
				dir_a_q <= bus_s3_q;
			end
			if (wr_go && sel[3]) begin
				dir_b_q <= bus_s3_q;
			end
		end
	end
	// pending flag: the pins follow only on the rise after a write
	always @(posedge clk) begin
		if (srst) begin
			wr_pend_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_go) begin
				wr_pend_q <= 1'b1;
			end else if (iowr_rise) begin
				wr_pend_q <= 1'b0;
			end
		end
	end
	// port a driver: output where the direction bit is one
	always @(posedge clk) begin
		if (srst) begin
			port_a_pins_out <= `PORT_RESET;
			port_a_pins_oe  <= 8'h00;
		end else if (clk_en) begin
			port_a_pins_oe <= dir_a_q;
			if (iowr_rise && wr_pend_q) begin
				port_a_pins_out <= pa_lat_q;
			end
		end
	end
	// port b driver: output where the direction bit is one
	always @(posedge clk) begin
		if (srst) begin
			port_b_pins_out <= `PORT_RESET;
			port_b_pins_oe  <= 8'h00;
		end else if (clk_en) begin
			port_b_pins_oe <= dir_b_q;
			if (iowr_rise && wr_pend_q) begin
				port_b_pins_out <= pb_lat_q;
			end
		end
	end
	// ----------------------------------------
	// read path and wait
	// ----------------------------------------
	wire mem_rd;
	wire port_rd;
	assign mem_rd  = ce_q && !iom_q && !rd_n;
	assign port_rd = ce_q && ((iom_q && !rd_n) || !iord_n);
	reg  [7:0] rd_data;
	// a port reads the pin for inputs and the latch for outputs
	function [7:0] pin_view;
		input [7:0] pins;
		input [7:0] lat;
		input [7:0] dir;
		begin
			pin_view = (pins & ~dir) | (lat & dir);
		end
	endfunction
	// port reads show pin level for inputs and the latch for outputs; direction registers read as nothing
	always @* begin
		rd_data = 8'h00;
		if (mem_rd) begin
			rd_data = mem_byte;
		end else if (sel[0]) begin
			rd_data = pin_view(pa_q, pa_lat_q, dir_a_q);
		end else if (sel[1]) begin
			rd_data = pin_view(pb_q, pb_lat_q, dir_b_q);
		end
	end
	// bus drive registers
	always @(posedge clk) begin
		if (srst) begin
			shared_addr_data_bus_out <= 8'h00;
			shared_addr_data_bus_oe  <= 1'b0;
		end else if (clk_en) begin
			shared_addr_data_bus_out <= rd_data;
			// drive only for memory or a port select, never a direction slot
			shared_addr_data_bus_oe <= mem_rd || (port_rd && !sel[2] && !sel[3]);
		end
	end
	// wait output: low while strobe high and enabled, freed next clock
	always @(posedge clk) begin
		if (srst) begin
			wait_out <= 1'b1;
			wait_oe  <= 1'b0;
		end else if (clk_en) begin
			if (ale && ce_now) begin
				wait_out <= 1'b0;
				wait_oe  <= 1'b1;
			end else begin
				wait_out <= 1'b1;
				wait_oe  <= 1'b0;
			end
		end
	end
endmodule // prom_io_port_bus_slave
`default_nettype wire

// ---- design/prom_io_defines.vh ----
// constants for the program memory and i/o port bus slave
`ifndef PROM_IO_DEFINES_VH
`define PROM_IO_DEFINES_VH
`define SEL_PORT_A   2'h0
`define SEL_PORT_B   2'h1
`define SEL_DIR_A    2'h2
`define SEL_DIR_B    2'h3
`define DIR_RESET    8'h00
`define PORT_RESET   8'h00
`define CTL_IDLE     7'h1c
`define MEM_ADDR_W   11
`define MEM_DEPTH    2048
`endif

// ---- dv/prom_io_props.sv ----
// assertions on the port bus slave pins
`timescale 1ns/1ps
`default_nettype none
module prom_io_props (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       addr_latch_strobe,
	input wire logic       read_strobe_n,
	input wire logic       port_read_strobe_n,
	input wire logic       port_write_strobe_n,
	input wire logic       chip_enable_low,
	input wire logic       chip_enable_high,
	input wire logic       shared_addr_data_bus_oe,
	input wire logic [7:0] port_a_pins_out,
	input wire logic [7:0] port_a_pins_oe,
	input wire logic [7:0] port_b_pins_out,
	input wire logic [7:0] port_b_pins_oe,
	input wire logic       wait_out,
	input wire logic       wait_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ----------------------------------------------------------------
	// bus, wait and port timing
	// ----------------------------------------------------------------
	property p_rst;
		@(posedge clk) disable iff (1'b0) srst |=> !port_a_pins_oe && !port_b_pins_oe;
	endproperty
	a_rst: assert property (p_rst) else $error("pins drive after reset");
	property p_idle;
		(read_strobe_n && port_read_strobe_n)[*8] |-> !shared_addr_data_bus_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("bus driven while idle");
	property p_cause;
		$rose(shared_addr_data_bus_oe) |-> !read_strobe_n || !port_read_strobe_n;
	endproperty
	a_cause: assert property (p_cause) else $error("bus driven with no read");
	property p_wait_on;
		(addr_latch_strobe && !chip_enable_low && chip_enable_high)[*8] |-> wait_oe;
	endproperty
	a_wait_on: assert property (p_wait_on) else $error("wait not driven");
	property p_wait_lvl;
		wait_oe |-> !wait_out;
	endproperty
	a_wait_lvl: assert property (p_wait_lvl) else $error("wait driven high");
	property p_wait_off;
		$fell(addr_latch_strobe) |-> ##[1:10] !wait_oe;
	endproperty
	a_wait_off: assert property (p_wait_off) else $error("wait not released");
	property p_no_ce;
		(addr_latch_strobe && !chip_enable_high)[*8] |-> !wait_oe;
	endproperty
	a_no_ce: assert property (p_no_ce) else $error("wait without enable");
	property p_pin_hold;
		(!port_write_strobe_n)[*8] |-> $stable(port_a_pins_out) && $stable(port_b_pins_out);
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin moved in write");
	property p_dir_hold;
		port_write_strobe_n[*8] |-> $stable(port_a_pins_oe) && $stable(port_b_pins_oe);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("direction moved");
	c_wait: cover property (wait_oe);
	c_read: cover property ($rose(shared_addr_data_bus_oe));
	c_write: cover property ($fell(port_write_strobe_n));
endmodule // prom_io_props
`default_nettype wire

// ---- dv/host_bus_model.sv ----
// host processor model driving the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	input  wire logic       clk,
	output var logic        addr_latch_strobe,
	output var logic        io_mem_select,
	output var logic        read_strobe_n,
	output var logic        port_read_strobe_n,
	output var logic        port_write_strobe_n,
	output var logic        chip_enable_low,
	output var logic        chip_enable_high,
	output var logic [2:0]  upper_addr,
	input  wire logic [7:0] shared_addr_data_bus_out,
	input  wire logic       shared_addr_data_bus_oe,
	output wire logic [7:0] shared_addr_data_bus_in
);
	logic       drv;
	logic [7:0] hd;
	// programming supply taken as tied to logic supply, no pin
	// a released bus shows the inverse of the last host byte
	assign shared_addr_data_bus_in = shared_addr_data_bus_oe ? shared_addr_data_bus_out :
		(drv ? hd : ~hd);
	initial begin
		{addr_latch_strobe, io_mem_select, drv, hd, upper_addr} = '0;
		{read_strobe_n, port_read_strobe_n, port_write_strobe_n} = 3'h7;
		{chip_enable_low, chip_enable_high} = 2'h2;
	end
	// step n edges, then just past the edge
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// address phase, address held past the strobe fall
	task latch(input logic [10:0] a, input logic io, input logic ce);
		{upper_addr, hd} = a;
		{io_mem_select, drv, addr_latch_strobe} = {io, 2'h3};
		{chip_enable_low, chip_enable_high} = {~ce, ce};
		cyc(9);
		addr_latch_strobe = 1'b0;
		cyc(6);
		drv = 1'b0;
	endtask
	// port write, data held past the strobe rise
	task wr(input logic [7:0] d);
		{drv, hd, port_write_strobe_n} = {1'b1, d, 1'b0};
		cyc(10);
		port_write_strobe_n = 1'b1;
		cyc(6);
		drv = 1'b0;
		cyc(4);
	endtask
	// read by port strobe or general strobe
	task rd(input logic prt, output logic [7:0] d, output logic oe);
		{read_strobe_n, port_read_strobe_n} = {prt, ~prt};
		cyc(10);
		{d, oe} = {shared_addr_data_bus_out, shared_addr_data_bus_oe};
		{read_strobe_n, port_read_strobe_n} = 2'h3;
		cyc(10);
	endtask
endmodule // host_bus_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// testbench for the program memory and port bus slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {logic [1:0] op; logic [1:0] a; logic [7:0] d; logic [8:0] exp;} row_t;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       clk_en = 1'b1;
	logic [7:0] ext_a = 8'h5a;
	logic [7:0] ext_b = 8'hc3;
	wire        addr_latch_strobe, io_mem_select, read_strobe_n, port_read_strobe_n;
	wire        port_write_strobe_n, chip_enable_low, chip_enable_high, wait_out, wait_oe;
	wire  [2:0] upper_addr;
	wire  [7:0] shared_addr_data_bus_in, shared_addr_data_bus_out;
	wire        shared_addr_data_bus_oe;
	wire  [7:0] port_a_pins_out, port_a_pins_oe, port_b_pins_out, port_b_pins_oe;
	wire  [7:0] port_a_pins_in = port_a_pins_oe & port_a_pins_out | ~port_a_pins_oe & ext_a;
	wire  [7:0] port_b_pins_in = port_b_pins_oe & port_b_pins_out | ~port_b_pins_oe & ext_b;
	int         num_errors = 0;
	int         n_compared = 0;
	row_t       r;
	logic [7:0] d;
	logic       oe;
	logic [8:0] got;
	logic [7:0] regs [4];
	// op 0 write, 1 port strobe read, 2 io read, 3 memory read
	row_t rows [9] = '{{2'h0, 2'h1, 8'h3c, 9'h03c}, {2'h0, 2'h3, 8'hf0, 9'h0f0},
		{2'h0, 2'h2, 8'h0f, 9'h00f}, {2'h0, 2'h0, 8'ha5, 9'h0a5}, {2'h1, 2'h0, 8'h00, 9'h155},
		{2'h2, 2'h1, 8'h00, 9'h133}, {2'h2, 2'h2, 8'h00, 9'h000}, {2'h1, 2'h3, 8'h00, 9'h000},
		{2'h3, 2'h0, 8'h00, 9'h1ff}};
	host_bus_model u_host (.*);
	prom_io_port_bus_slave u_dut (.*);
	initial forever #5 clk = ~clk;
	// ----------------------------------------------------------------
	// checks and closing report
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [8:0] exp, input logic [8:0] g);
		n_compared++;
		if (g !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, g);
		end
	endtask
	task final_report;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 srst = 1'b0;
		u_host.cyc(5);
		foreach (rows[i]) begin
			r = rows[i];
			u_host.latch({9'h000, r.a}, r.op ? r.op != 2'h3 : r.a[0], 1'b1);
			if (r.op == 2'h0) begin
				u_host.wr(r.d);
				regs = '{port_a_pins_out, port_b_pins_out, port_a_pins_oe, port_b_pins_oe};
				got = {1'b0, regs[r.a]};
			end else begin
				u_host.rd(r.op == 2'h1, d, oe);
				got = oe ? {oe, d} : 9'h000;
			end
			chk("row", r.exp, got);
		end
		// write with enables inactive leaves the latch alone
		u_host.latch(11'h000, 1'b0, 1'b0);
		u_host.wr(8'h00);
		chk("refused", 9'h0a5, {1'b0, port_a_pins_out});
		// mid-run reset returns every pin to input
		srst = 1'b1;
		u_host.cyc(2);
		chk("dir", 9'h000, {1'b0, port_a_pins_oe | port_b_pins_oe});
		srst = 1'b0;
		u_host.cyc(5);
		u_host.latch(11'h000, 1'b1, 1'b1);
		u_host.rd(1'b1, d, oe);
		chk("pin", 9'h15a, {oe, d});
		final_report();
	end
endmodule // tb_top
bind prom_io_port_bus_slave prom_io_props u_props (.*);
`default_nettype wire
